// >>> rtl/dssc_regs.vh
// Constants of the diagnosis shadow and status capture block
// How it works
// RL1 - Events during a transfer go to the shadow, never the outgoing snapshot.
// RL2 - After snapshot shifts out, shadow moves into status; both reach the output.
// RL3 - Fault output stays high until the new diagnosis has been read.
// RL4 - A read reports events before select fell; later ones wait for next read.
// RL5 - Host asks main diagnosis with control bits 0 0 1 0 0 0.
// RL6 - Flags returned by a read are cleared once the host has read them.
// RL7 - Response bits B7..B0 carry eight fail flags, one means failure.
// RL8 - On select rising, input register loads only with 16 clocks and valid key.
// RL9 - Fault output is high while any status flag is set.
`ifndef DSSC_REGS_VH
`define DSSC_REGS_VH
`define DSSC_WORD_W 16
`define DSSC_BITCNT_W 5
`define DSSC_BITS_FULL 5'h10
`define DSSC_CTRL_HI 15
`define DSSC_CTRL_LO 10
`define DSSC_CMD_DIAG1 6'h08
`define DSSC_CMD_DIAG2 6'h10
`define DSSC_CMD_DIAG3 6'h18
`define DSSC_CMD_SET1 6'h01
`define DSSC_CMD_SET2 6'h02
`define DSSC_CMD_SET3 6'h03
`define DSSC_RESP_DIAG1 8'h10
`define DSSC_RESP_DIAG2 8'h20
`define DSSC_RESP_DIAG3 8'h30
`define DSSC_RESP_IDLE 8'h02
`define DSSC_FLAGS_ZERO 8'h00
`define DSSC_WORD_ZERO 16'h0000
`define DSSC_SERR_BIT 7
`define DSSC_CNT_ZERO 5'h00
`define DSSC_CNT_STEP 5'h01
`define DSSC_CNT_SAT 5'h11
`define DSSC_LOW7_ZERO 7'h00
`define DSSC_PAD2 2'b00
`endif

// >>> rtl/dssc_capture.v
// Diagnosis shadow/status capture with 16-bit serial slave
`include "dssc_regs.vh"
module dssc_capture (
  sys_clk,
  rst_b,
  sel_b,
  sck,
  sdi,
  fail_events,
  sdo,
  sdo_oe_b,
  fault,
  in_word,
  in_word_strobe
);
  input wire sys_clk;
  input wire rst_b;
  input wire sel_b;
  input wire sck;
  input wire sdi;
  input wire [7:0] fail_events;
  output reg sdo;
  output reg sdo_oe_b;
  output reg fault;
  output reg [15:0] in_word;
  output reg in_word_strobe;

  // Pin samples, used for edge detection; the sel_b sample also gives busy
  reg sel_b_ff;
  reg sck_ff;
  // Serial shifters and clock counter
  reg [15:0] rx_ff;
  reg [15:0] tx_ff;
  reg [4:0] cnt_ff;
  // Diagnosis storage
  reg [7:0] status_ff;
  reg [7:0] shadow_ff;
  reg [7:0] sent_ff;
  reg serr_ff;
  reg serr_sent_ff;
  // Command bookkeeping
  reg diag1_ff;
  reg diag2_ff;
  reg [7:0] last_cmd_ff;

  // Next values
  reg [15:0] nxt_rx;
  reg [15:0] nxt_tx;
  reg [4:0] nxt_cnt;
  reg [7:0] nxt_status;
  reg [7:0] nxt_shadow;
  reg [7:0] nxt_sent;
  reg nxt_serr;
  reg nxt_serr_sent;
  reg nxt_diag1;
  reg nxt_diag2;
  reg [7:0] nxt_last_cmd;
  reg nxt_sdo;
  reg nxt_sdo_oe_b;
  reg nxt_fault;
  reg [15:0] nxt_in_word;
  reg nxt_in_word_strobe;

  // Edges of the sampled pins; clock edges count only inside a frame
  wire fall_sel = sel_b_ff & ~sel_b;
  wire rise_sel = ~sel_b_ff & sel_b;
  wire fall_sck = sck_ff & ~sck & ~sel_b;
  wire rise_sck = ~sck_ff & sck & ~sel_b;
  wire busy = ~sel_b_ff;
  wire [5:0] ctrl = rx_ff[`DSSC_CTRL_HI:`DSSC_CTRL_LO];

  function key_ok;
    input [5:0] c;
    begin
      key_ok = (c == `DSSC_CMD_DIAG1) || (c == `DSSC_CMD_DIAG2) ||
        (c == `DSSC_CMD_DIAG3) || (c == `DSSC_CMD_SET1) ||
        (c == `DSSC_CMD_SET2) || (c == `DSSC_CMD_SET3);
    end
  endfunction

  function [15:0] reply;
    input [7:0] head;
    input [7:0] flags;
    begin
      reply = {head, flags};
    end
  endfunction

  // Reply word chosen by the previous command, frozen at select fall
  wire [15:0] snap_word =
    (last_cmd_ff == `DSSC_RESP_DIAG1) ? reply(last_cmd_ff, status_ff) : // RL7
    (last_cmd_ff == `DSSC_RESP_DIAG2) ? reply(last_cmd_ff, {serr_ff, `DSSC_LOW7_ZERO}) :
    reply(last_cmd_ff, `DSSC_FLAGS_ZERO);

  wire good = (cnt_ff == `DSSC_BITS_FULL) && key_ok(ctrl);
  wire is_d1 = good && (ctrl == `DSSC_CMD_DIAG1);
  wire is_d2 = good && (ctrl == `DSSC_CMD_DIAG2);

  always @*
  begin
    nxt_rx = rx_ff;
    nxt_tx = tx_ff;
    nxt_cnt = cnt_ff;
    nxt_status = status_ff;
    nxt_shadow = shadow_ff;
    nxt_sent = sent_ff;
    nxt_serr = serr_ff;
    nxt_serr_sent = serr_sent_ff;
    nxt_diag1 = diag1_ff;
    nxt_diag2 = diag2_ff;
    nxt_last_cmd = last_cmd_ff;
    nxt_sdo = sdo;
    nxt_sdo_oe_b = sdo_oe_b;
    nxt_in_word = in_word;
    nxt_in_word_strobe = 1'b0;

    // Events never touch the snapshot in flight; they park in the shadow
    if (busy)
      nxt_shadow = shadow_ff | fail_events; // RL1
    else
    begin
      nxt_status = status_ff | shadow_ff | fail_events; // RL2
      nxt_shadow = `DSSC_FLAGS_ZERO; // RL2
    end

    if (rise_sck)
    begin
      nxt_rx = {rx_ff[`DSSC_WORD_W-2:0], sdi};
      // Count saturates past full so an overlong frame is still refused
      if (cnt_ff != `DSSC_CNT_SAT)
        nxt_cnt = cnt_ff + `DSSC_CNT_STEP;
    end

    if (fall_sck)
    begin
      nxt_sdo = tx_ff[`DSSC_WORD_W-1];
      nxt_tx = {tx_ff[`DSSC_WORD_W-2:0], 1'b0};
    end

    if (fall_sel)
    begin
      // Snapshot frozen at select fall; answer is for the previous command
      nxt_sent = status_ff; // RL4
      nxt_serr_sent = serr_ff;
      nxt_cnt = `DSSC_CNT_ZERO;
      nxt_sdo_oe_b = 1'b0;
      nxt_tx = snap_word;
      nxt_sdo = snap_word[`DSSC_WORD_W-1];
      nxt_diag1 = (last_cmd_ff == `DSSC_RESP_DIAG1);
      nxt_diag2 = (last_cmd_ff == `DSSC_RESP_DIAG2);
    end

    if (rise_sel)
    begin
      nxt_sdo_oe_b = 1'b1;
      if (good)
      begin
        nxt_in_word = rx_ff; // RL8
        nxt_in_word_strobe = 1'b1; // RL8
      end
      // Read flags cleared; events since select fall survive via shadow
      if (diag1_ff && cnt_ff == `DSSC_BITS_FULL)
        nxt_status = (status_ff & ~sent_ff) | shadow_ff | fail_events; // RL6
      if (diag2_ff && cnt_ff == `DSSC_BITS_FULL && serr_sent_ff)
        nxt_serr = 1'b0; // RL6
      // A refused word raises the serial error; set wins over a clear
      if (!good)
        nxt_serr = 1'b1;
      if (is_d1)
        nxt_last_cmd = `DSSC_RESP_DIAG1;
      else if (is_d2)
        nxt_last_cmd = `DSSC_RESP_DIAG2;
      else if (good)
        nxt_last_cmd = {`DSSC_PAD2, ctrl};
      else
        nxt_last_cmd = `DSSC_RESP_IDLE;
    end

    // Fault stays until status flags, including transferred shadow, are read
    nxt_fault = (|status_ff) | (|shadow_ff); // RL3 RL9
  end

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sel_b_ff <= 1'b1;
      sck_ff <= 1'b1;
      rx_ff <= `DSSC_WORD_ZERO;
      tx_ff <= `DSSC_WORD_ZERO;
      cnt_ff <= `DSSC_CNT_ZERO;
      status_ff <= `DSSC_FLAGS_ZERO;
      shadow_ff <= `DSSC_FLAGS_ZERO;
      sent_ff <= `DSSC_FLAGS_ZERO;
      diag1_ff <= 1'b0;
      diag2_ff <= 1'b0;
      serr_ff <= 1'b0;
      serr_sent_ff <= 1'b0;
      last_cmd_ff <= `DSSC_RESP_IDLE;
      sdo <= 1'b0;
      sdo_oe_b <= 1'b1;
      fault <= 1'b0;
      in_word <= `DSSC_WORD_ZERO;
      in_word_strobe <= 1'b0;
    end
    else
    begin
      sel_b_ff <= sel_b;
      sck_ff <= sck;
      rx_ff <= nxt_rx;
      tx_ff <= nxt_tx;
      cnt_ff <= nxt_cnt;
      status_ff <= nxt_status;
      shadow_ff <= nxt_shadow;
      sent_ff <= nxt_sent;
      diag1_ff <= nxt_diag1;
      diag2_ff <= nxt_diag2;
      serr_ff <= nxt_serr;
      serr_sent_ff <= nxt_serr_sent;
      last_cmd_ff <= nxt_last_cmd;
      sdo <= nxt_sdo;
      sdo_oe_b <= nxt_sdo_oe_b;
      fault <= nxt_fault;
      in_word <= nxt_in_word;
      in_word_strobe <= nxt_in_word_strobe;
    end
  end
endmodule

// >>> verification/dssc_capture_properties.sv
// Port checker of the capture block
module dssc_capture_properties (
  input wire logic sys_clk, rst_b, sel_b, sck, sdi, sdo, sdo_oe_b, fault, in_word_strobe,
  input wire logic [7:0] fail_events,
  input wire logic [15:0] in_word
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_oe_on; $fell(sel_b) |-> ##[1:3] !sdo_oe_b; endproperty
  a_oe_on: assert property (p_oe_on) else $error("oe late");
  property p_oe_off; $rose(sel_b) |-> ##[1:3] sdo_oe_b; endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe stuck");
  property p_sdo; $rose(sck) |=> $stable(sdo); endproperty
  a_sdo: assert property (p_sdo) else $error("sdo moved");
  property p_stb; in_word_strobe |-> sel_b && $past(sel_b); endproperty
  a_stb: assert property (p_stb) else $error("strobe in frame");
  property p_iw; $changed(in_word) |-> in_word_strobe; endproperty
  a_iw: assert property (p_iw) else $error("word moved");
  property p_flt; |fail_events |-> ##[1:3] fault; endproperty
  a_flt: assert property (p_flt) else $error("fault missing");
  // Clearing needs a committed read, so a long idle keeps the fault
  property p_hold; (fault && sel_b) [*6] |=> fault; endproperty
  a_hold: assert property (p_hold) else $error("fault dropped");
  property p_drop;
    $fell(fault) |-> in_word_strobe || $past(in_word_strobe) || $past(in_word_strobe, 2);
  endproperty
  a_drop: assert property (p_drop) else $error("fault fell unread");
  c_rise: cover property ($rose(fault));
  c_fall: cover property ($fell(fault));
  c_stb: cover property (in_word_strobe);
endmodule
bind dssc_capture dssc_capture_properties u_chk (.*);

// >>> verification/dssc_host.sv
// Serial host model
module dssc_host (
  input wire logic sys_clk, sdo,
  output logic sel_b = 1, sck = 1, sdi = 1
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Slow edges, four cycles each, leave room for the synchronisers
  task xfer(input logic [15:0] d, input int n, output logic [15:0] r);
    sel_b = 0;
    w(4);
    for (int i = 15; i > 15 - n; i--)
    begin
      sck = 0;
      sdi = d[i];
      w(4);
      sck = 1;
      r = {r[14:0], sdo};
      w(4);
    end
    sel_b = 1;
    sdi = 1;
    w(8);
  endtask
endmodule

// >>> verification/tb.sv
// Bench of the capture block
`include "dssc_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, rst_b = 0;
  logic [7:0] fail_events, e;
  logic [15:0] r, q[$];
  wire sel_b, sck, sdi, sdo, sdo_oe_b, fault, in_word_strobe;
  wire [15:0] in_word;
  int errors, checks_done;
  dssc_capture dut (.*);
  dssc_host h (.sys_clk, .sdo, .sel_b, .sck, .sdi);
  initial forever #20 sys_clk = ~sys_clk;
  task chk(input string n, input logic [15:0] s, x);
    checks_done++;
    if (s !== x)
    begin
      errors++;
      $display("BAD %s exp %h got %h", n, x, s);
    end
  endtask
  task finish_test;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task rd(input logic [15:0] d, x);
    q.push_back(d);
    h.xfer(d, 16, r);
    chk("reply", r, x);
  endtask
  task ev(input logic [7:0] v);
    fail_events = v;
    h.w(1);
    fail_events = 0;
  endtask
  always @(posedge sys_clk) if (in_word_strobe) chk("in_word", in_word, q.size() ? q.pop_front() : 'x);
  initial
  begin
    #400000;
    errors++;
    finish_test;
  end
  initial
  begin
    fail_events = `DSSC_FLAGS_ZERO;
    void'($urandom(32'h5B87));
    h.w(10);
    rst_b = 1;
    h.w(2);
    chk("sdo_oe_b", sdo_oe_b, 1);
    rd(16'h2000, {`DSSC_RESP_IDLE, 8'h00});
    e = $urandom | 1;
    ev(e);
    h.w(3);
    chk("fault", fault, 1);
    rd(16'h2000, {`DSSC_RESP_DIAG1, e});
    chk("fault", fault, 0);
    e = $urandom | 1;
    fork
      rd(16'h2000, {`DSSC_RESP_DIAG1, 8'h00});
      begin
        h.w(40);
        ev(e);
      end
    join
    chk("fault", fault, 1);
    rd(16'h2000, {`DSSC_RESP_DIAG1, e});
    h.xfer(16'h2000, 15, r);
    h.xfer(16'hFC00, 16, r);
    q.push_back(16'h4000);
    h.xfer(16'h4000, 16, r);
    rd(16'h2000, {`DSSC_RESP_DIAG2, 8'h80});
    finish_test;
  end
endmodule
